/* logic/pmcg_top.v */
// power mode control, cpu slowdown and per-module clock gating
`timescale 1ns/1ps
`include "pmcg_map.vh"

// Function
// - sleep instruction stops system clock, on-chip oscillator and code execution
// - idle instruction stops cpu; system clock keeps peripherals running unless their stop-in-idle bit is set
// - enabled interrupt, watchdog time-out or any reset ends low-power state
// - fail-safe clock monitor is inactive during sleep
// - in sleep the low-power rc oscillator runs only if watchdog enabled
// - watchdog count is cleared before sleep is entered when enabled
// - sleep disables system-clocked peripherals; external-clock ones may run
// - waking from sleep resumes on the clock source selected at entry
// - entering idle clears the watchdog counter
// - in idle the rc oscillator runs if watchdog or monitor enabled
// - waking from idle restores cpu clock and execution immediately
// - interrupt during power-save instruction is held until entry, then wakes
// - slowdown only divides cpu clock; system and peripheral clocks unchanged
// - slowdown enable at divider bit 11 activates reduced cpu clock
// - ratio field bits 14:12 picks 1:1 to 1:128, default 1:1
// - return bit 15 set makes an interrupt restore full speed
// - power-off bit gates module clocks and blocks its register access
// - clearing function enable stops module but keeps registers usable
// - stop-in-idle bit halts that module while idle; default keep running
module pmcg_top (
    input  wire        SYS_CLK,        // system clock, 20 MHz
    input  wire        RST_N,          // synchronous reset, active low
    input  wire        PSEL,           // apb select
    input  wire        PENABLE,        // apb access phase
    input  wire        PWRITE,         // apb write
    input  wire [11:0] PADDR,          // apb byte address
    input  wire [31:0] PWDATA,         // apb write data
    output reg  [31:0] PRDATA,         // apb read data
    output reg         PREADY,         // apb ready
    output reg         PSLVERR,        // apb error, unmapped address
    input  wire        PWR_SAVE_REQ,   // power-save instruction strobe
    input  wire        PWR_SAVE_OP,    // operand: 0 sleep, 1 idle
    input  wire        IRQ_PENDING,    // an enabled interrupt is pending
    input  wire        WDT_TIMEOUT,    // watchdog time-out pulse
    input  wire        EXT_CLK_MOD,    // external clock flag, shared by all modules
    output reg         CPU_CLK_EN,     // cpu clock enable pulse
    output reg         SYS_OSC_EN,     // system oscillator running
    output reg         LOW_POWER_RC_OSCILLATOR_EN,        // low-power rc oscillator running
    output reg         FAIL_SAFE_CLOCK_MONITOR_ACTIVE,    // fail-safe monitor active
    output reg         WDT_CLEAR,      // watchdog counter clear pulse
    output reg         WAKE,           // wake-up pulse to the core
    output reg  [2:0]  ACTIVE_OSC,     // oscillator to run after wake
    output reg  [7:0]  MOD_CLK_EN,     // per-module clock enable
    output reg  [7:0]  MOD_RUN,        // per-module function running
    output reg  [7:0]  MOD_REG_EN      // per-module register access allowed
);

    reg  [15:0] clock_divider_control_reg;
    reg  [7:0]  pwroff_reg;
    reg  [7:0]  funcen_reg;
    reg  [7:0]  idlstop_reg;
    reg  [2:0]  cfg_reg;
    reg  [2:0]  oscsel_reg;
    reg  [2:0]  entry_osc_reg;
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg         slow_reg;
    reg  [6:0]  div_cnt_reg;
    reg         held_irq_reg;
    reg  [2:0]  op_sleep_rc;

    wire        wr_en  = PSEL & PENABLE & PWRITE;
    wire        rd_en  = PSEL & PENABLE & ~PWRITE;
    wire        wdt_on  = cfg_reg[`PMCG_CFG_WDT_BIT];
    wire        fail_safe_clock_monitor_on = cfg_reg[`PMCG_CFG_FAIL_SAFE_CLOCK_MONITOR_BIT];
    wire        locked  = cfg_reg[`PMCG_CFG_LOCK_BIT];
    wire [2:0]  ratio   = clock_divider_control_reg[`PMCG_RATIO_HI:`PMCG_RATIO_LO];
    wire        wake_ev = IRQ_PENDING | WDT_TIMEOUT | held_irq_reg;
    wire        mapped  = (PADDR == `PMCG_ADDR_CLOCK_DIVIDER_CONTROL) |
                          (PADDR == `PMCG_ADDR_PWROFF) |
                          (PADDR == `PMCG_ADDR_FUNCEN) |
                          (PADDR == `PMCG_ADDR_IDLSTOP) |
                          (PADDR == `PMCG_ADDR_CFG) |
                          (PADDR == `PMCG_ADDR_STATUS) |
                          (PADDR == `PMCG_ADDR_OSCSEL);

    // divide mask: code n gives period 2^n
    wire [6:0]  div_mask = (7'h01 << ratio) - 7'h01;
    wire        div_tick = ((div_cnt_reg & div_mask) == 7'h00);

    // register writes
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            clock_divider_control_reg  <= `PMCG_CLOCK_DIVIDER_CONTROL_RST;
            pwroff_reg  <= `PMCG_MOD_RST;
            funcen_reg  <= `PMCG_FEN_RST;
            idlstop_reg <= `PMCG_MOD_RST;
            cfg_reg     <= `PMCG_CFG_RST;
            oscsel_reg  <= `PMCG_OSC_RST;
        end else if (wr_en) begin
            case (PADDR)
            `PMCG_ADDR_CLOCK_DIVIDER_CONTROL:  clock_divider_control_reg  <= PWDATA[15:0];
            `PMCG_ADDR_PWROFF:  pwroff_reg  <= PWDATA[7:0];
            `PMCG_ADDR_FUNCEN:  funcen_reg  <= PWDATA[7:0];
            `PMCG_ADDR_IDLSTOP: idlstop_reg <= PWDATA[7:0];
            `PMCG_ADDR_CFG:     cfg_reg     <= PWDATA[2:0];
            `PMCG_ADDR_OSCSEL: begin
                if (!locked) begin
                    oscsel_reg <= PWDATA[2:0];
                end
            end
            default: begin
            end
            endcase
        end
    end

    // apb answer, zero wait states
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~mapped;
            if (PSEL & ~PENABLE & ~PWRITE) begin
                case (PADDR)
                `PMCG_ADDR_CLOCK_DIVIDER_CONTROL:  PRDATA <= {16'h0000, clock_divider_control_reg};
                `PMCG_ADDR_PWROFF:  PRDATA <= {24'h000000, pwroff_reg};
                `PMCG_ADDR_FUNCEN:  PRDATA <= {24'h000000, funcen_reg};
                `PMCG_ADDR_IDLSTOP: PRDATA <= {24'h000000, idlstop_reg};
                `PMCG_ADDR_CFG:     PRDATA <= {29'h00000000, cfg_reg};
                `PMCG_ADDR_STATUS:  PRDATA <= {27'h0000000, slow_reg,
                                               op_sleep_rc[0], state_reg,
                                               held_irq_reg};
                `PMCG_ADDR_OSCSEL:  PRDATA <= {29'h00000000, oscsel_reg};
                default:            PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // power state machine
    always @* begin
        state_next = state_reg;
        case (state_reg)
        `PMCG_ST_RUN: begin
            if (PWR_SAVE_REQ && PWR_SAVE_OP == `PMCG_OP_SLEEP) begin
                state_next = `PMCG_ST_SLEEP;
            end else if (PWR_SAVE_REQ) begin
                state_next = `PMCG_ST_IDLE;
            end
        end
        `PMCG_ST_SLEEP, `PMCG_ST_IDLE: begin
            if (wake_ev) begin
                state_next = `PMCG_ST_RUN;
            end
        end
        default: state_next = `PMCG_ST_RUN;
        endcase
    end

    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            state_reg     <= `PMCG_ST_RUN;
            held_irq_reg  <= 1'b0;
            entry_osc_reg <= `PMCG_OSC_RST;
            op_sleep_rc   <= 3'h0;
            WAKE          <= 1'b0;
            WDT_CLEAR     <= 1'b0;
        end else begin
            state_reg <= state_next;
            // irq with the instruction is held until entry completes
            held_irq_reg <= (state_reg == `PMCG_ST_RUN) & PWR_SAVE_REQ &
                            IRQ_PENDING;
            op_sleep_rc  <= {2'h0, state_reg == `PMCG_ST_SLEEP};
            WAKE <= (state_reg != `PMCG_ST_RUN) &
                    (state_next == `PMCG_ST_RUN);
            // watchdog cleared on entry to idle, and to sleep only when enabled
            WDT_CLEAR <= (state_reg == `PMCG_ST_RUN) & PWR_SAVE_REQ &
                         (wdt_on | PWR_SAVE_OP == `PMCG_OP_IDLE);
            if (state_reg == `PMCG_ST_RUN && state_next == `PMCG_ST_SLEEP) begin
                entry_osc_reg <= oscsel_reg;
            end
        end
    end

    // cpu slowdown: interrupt may restore full speed
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            slow_reg    <= 1'b0;
            div_cnt_reg <= 7'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
            if (clock_divider_control_reg[`PMCG_ROI_BIT] && IRQ_PENDING) begin
                slow_reg <= 1'b0;
            end else begin
                slow_reg <= clock_divider_control_reg[`PMCG_SLOW_BIT];
            end
        end
    end

    // roi write-back handled by slow flag; clock and oscillator outputs
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            CPU_CLK_EN  <= 1'b0;
            SYS_OSC_EN  <= 1'b1;
            LOW_POWER_RC_OSCILLATOR_EN     <= 1'b0;
            FAIL_SAFE_CLOCK_MONITOR_ACTIVE <= 1'b0;
            ACTIVE_OSC  <= `PMCG_OSC_RST;
        end else begin
            CPU_CLK_EN  <= (state_next == `PMCG_ST_RUN) &
                           (~slow_reg | div_tick);
            SYS_OSC_EN  <= (state_next != `PMCG_ST_SLEEP);
            FAIL_SAFE_CLOCK_MONITOR_ACTIVE <= fail_safe_clock_monitor_on &
                           (state_next != `PMCG_ST_SLEEP);
            case (state_next)
            `PMCG_ST_SLEEP: LOW_POWER_RC_OSCILLATOR_EN <= wdt_on;
            `PMCG_ST_IDLE:  LOW_POWER_RC_OSCILLATOR_EN <= wdt_on | fail_safe_clock_monitor_on;
            default:        LOW_POWER_RC_OSCILLATOR_EN <= wdt_on | fail_safe_clock_monitor_on;
            endcase
            ACTIVE_OSC  <= (state_reg == `PMCG_ST_SLEEP) ?
                           entry_osc_reg : oscsel_reg;
        end
    end

    // per-module gating
    genvar m;
    generate
        for (m = 0; m < `PMCG_NMOD; m = m + 1) begin : g_mod
            always @(posedge SYS_CLK) begin
                if (!RST_N) begin
                    MOD_CLK_EN[m] <= 1'b1;
                    MOD_RUN[m]    <= 1'b0;
                    MOD_REG_EN[m] <= 1'b1;
                end else begin
                    MOD_CLK_EN[m] <= ~pwroff_reg[m] &
                        ~((state_next == `PMCG_ST_SLEEP) & ~EXT_CLK_MOD) &
                        ~((state_next == `PMCG_ST_IDLE) & idlstop_reg[m]);
                    MOD_RUN[m]    <= ~pwroff_reg[m] & funcen_reg[m] &
                        ~((state_next == `PMCG_ST_SLEEP) & ~EXT_CLK_MOD) &
                        ~((state_next == `PMCG_ST_IDLE) & idlstop_reg[m]);
                    MOD_REG_EN[m] <= ~pwroff_reg[m];
                end
            end
        end
    endgenerate

endmodule

/* logic/pmcg_map.vh */
// register offsets, field positions and codes for the power mode clock gating
`ifndef PMCG_MAP_VH
`define PMCG_MAP_VH
// apb register byte addresses
`define PMCG_ADDR_CLOCK_DIVIDER_CONTROL   12'h000
`define PMCG_ADDR_PWROFF   12'h004
`define PMCG_ADDR_FUNCEN   12'h008
`define PMCG_ADDR_IDLSTOP  12'h00C
`define PMCG_ADDR_CFG      12'h010
`define PMCG_ADDR_STATUS   12'h014
`define PMCG_ADDR_OSCSEL   12'h018
// clock divider control fields
`define PMCG_ROI_BIT       15
`define PMCG_RATIO_HI      14
`define PMCG_RATIO_LO      12
`define PMCG_SLOW_BIT      11
`define PMCG_CLOCK_DIVIDER_CONTROL_RST    16'h0000
// config register fields
`define PMCG_CFG_WDT_BIT   0
`define PMCG_CFG_FAIL_SAFE_CLOCK_MONITOR_BIT  1
`define PMCG_CFG_LOCK_BIT  2
`define PMCG_CFG_RST       3'h0
// number of peripheral modules
`define PMCG_NMOD          8
`define PMCG_MOD_RST       8'h00
`define PMCG_FEN_RST       8'hFF
// power save operands
`define PMCG_OP_SLEEP      1'b0
`define PMCG_OP_IDLE       1'b1
// state codes
`define PMCG_ST_RUN        2'h0
`define PMCG_ST_SLEEP      2'h1
`define PMCG_ST_IDLE       2'h2
// oscillator select reset value
`define PMCG_OSC_RST       3'h0
`endif

/* bench/pmcg_props.sv */
// concurrent checks on the power mode clock gating top ports
`timescale 1ns/1ps
module pmcg_props (
    input wire       SYS_CLK,      // clock
    input wire       RST_N,        // reset
    input wire       PWR_SAVE_REQ, // power-save strobe
    input wire       PWR_SAVE_OP,  // operand
    input wire       IRQ_PENDING,  // interrupt
    input wire       WDT_TIMEOUT,  // watchdog time-out
    input wire       EXT_CLK_MOD,  // external module clock
    input wire       CPU_CLK_EN,   // cpu clock enable
    input wire       SYS_OSC_EN,   // system oscillator
    input wire       FAIL_SAFE_CLOCK_MONITOR_ACTIVE,  // monitor active
    input wire       WDT_CLEAR,    // watchdog clear
    input wire       WAKE,         // wake pulse
    input wire [2:0] ACTIVE_OSC,   // oscillator choice
    input wire [7:0] MOD_CLK_EN,   // module clocks
    input wire [7:0] MOD_REG_EN    // module register access
);
    reg  lp_reg;
    wire run_req = PWR_SAVE_REQ && !lp_reg;
    // tracks low-power state from request to wake pulse
    always @(posedge SYS_CLK) begin
        if (!RST_N || WAKE) lp_reg <= 1'b0;
        else if (run_req) lp_reg <= 1'b1;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_run_req;
        run_req;
    endsequence
    sequence s_req_irq;
        run_req && IRQ_PENDING;
    endsequence
    AST_SLEEP_STOP: assert property (s_run_req and !PWR_SAVE_OP
        |=> !SYS_OSC_EN && !CPU_CLK_EN) else $error("sleep entry wrong");
    AST_IDLE_KEEP: assert property (s_run_req and PWR_SAVE_OP &&
        !IRQ_PENDING |=> SYS_OSC_EN && !CPU_CLK_EN)
        else $error("idle entry wrong");
    AST_FAIL_SAFE_CLOCK_MONITOR_OFF: assert property (!SYS_OSC_EN |-> !FAIL_SAFE_CLOCK_MONITOR_ACTIVE)
        else $error("monitor active in sleep");
    AST_IDLE_WCLR: assert property (s_run_req and PWR_SAVE_OP
        |=> WDT_CLEAR) else $error("no watchdog clear on idle");
    AST_WAKE_EVT: assert property (lp_reg && !WAKE &&
        (IRQ_PENDING || WDT_TIMEOUT) |-> ##[1:3] WAKE)
        else $error("no wake on event");
    AST_WAKE_CLK: assert property (WAKE |-> SYS_OSC_EN && CPU_CLK_EN)
        else $error("clocks not back on wake");
    AST_OSC_HOLD: assert property (lp_reg && !SYS_OSC_EN
        |-> $stable(ACTIVE_OSC)) else $error("oscillator changed");
    AST_GATE: assert property ((MOD_CLK_EN & ~MOD_REG_EN) == 8'h00)
        else $error("clock on for powered-off module");
    AST_SLEEP_MOD: assert property (!SYS_OSC_EN && !EXT_CLK_MOD
        |-> MOD_CLK_EN == 8'h00) else $error("module clock in sleep");
    AST_HELD_IRQ: assert property (s_req_irq |-> ##[2:4] WAKE)
        else $error("held interrupt did not wake");
endmodule
bind pmcg_top pmcg_props u_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .PWR_SAVE_REQ(PWR_SAVE_REQ), .PWR_SAVE_OP(PWR_SAVE_OP),
    .IRQ_PENDING(IRQ_PENDING), .WDT_TIMEOUT(WDT_TIMEOUT),
    .EXT_CLK_MOD(EXT_CLK_MOD), .CPU_CLK_EN(CPU_CLK_EN),
    .SYS_OSC_EN(SYS_OSC_EN), .FAIL_SAFE_CLOCK_MONITOR_ACTIVE(FAIL_SAFE_CLOCK_MONITOR_ACTIVE), .WAKE(WAKE),
    .WDT_CLEAR(WDT_CLEAR), .ACTIVE_OSC(ACTIVE_OSC),
    .MOD_CLK_EN(MOD_CLK_EN), .MOD_REG_EN(MOD_REG_EN));

/* bench/pmcg_irq_model.sv */
// interrupt controller model with programmable raise latency
`timescale 1ns/1ps
module pmcg_irq_model (
    input  wire       sys_clk,     // clock
    input  wire       rst_n,       // reset
    input  wire       irq_req,     // source asserts interrupt
    input  wire [2:0] lat,         // pending shows lat+1 cycles after irq_req
    output reg        irq_pending  // enabled interrupt pending
);
    reg [2:0] cnt_reg;
    always @(posedge sys_clk) begin
        if (!rst_n || !irq_req) {cnt_reg, irq_pending} <= 4'h0;
        else if (cnt_reg < lat) cnt_reg <= cnt_reg + 3'h1;
        else irq_pending <= 1'b1;
    end
endmodule

/* bench/tb_pmcg_top.sv */
// self-checking bench for the power mode clock gating top
`timescale 1ns/1ps
`include "pmcg_map.vh"
module tb_pmcg_top;
    reg         clk, rst_n, psel, pen, pwr, req, op, wto, ext, irq_req;
    reg  [2:0]  lat, osv;
    reg  [11:0] pa;
    reg  [31:0] pw, seed, r, f, s;
    reg  [32:0] e;
    reg  [32:0] q[$];
    wire [31:0] prd;
    wire        prdy, perr, irq, cen, osc, low_power_rc_oscillator, fail_safe_clock_monitor, wclr, wake;
    wire [2:0]  aosc;
    wire [7:0]  mclk, mrun, mreg;
    integer     errors, cmp_count, i, n;
    pmcg_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pw), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .PWR_SAVE_REQ(req), .PWR_SAVE_OP(op),
        .IRQ_PENDING(irq), .WDT_TIMEOUT(wto), .EXT_CLK_MOD(ext),
        .CPU_CLK_EN(cen), .SYS_OSC_EN(osc), .LOW_POWER_RC_OSCILLATOR_EN(low_power_rc_oscillator),
        .FAIL_SAFE_CLOCK_MONITOR_ACTIVE(fail_safe_clock_monitor), .WDT_CLEAR(wclr), .WAKE(wake),
        .ACTIVE_OSC(aosc), .MOD_CLK_EN(mclk), .MOD_RUN(mrun),
        .MOD_REG_EN(mreg));
    pmcg_irq_model u_irq (.sys_clk(clk), .rst_n(rst_n), .irq_req(irq_req),
        .lat(lat), .irq_pending(irq));
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input [8*6-1:0] nm);
        begin
            cmp_count++;
            if (seen !== exp) begin
                errors++;
                $display("ERROR %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task bound(input integer k, input integer lim);
        if (k >= lim) begin
            errors++;
            print_verdict;
        end
    endtask
    // one apb transfer; read expectation {slverr, data} is queued
    task apb(input w, input [11:0] a, input [31:0] d, input [32:0] x);
        integer k;
        begin
            {psel, pen, pwr, pa, pw} <= {2'b10, w, a, d};
            if (!w) q.push_back(x);
            @(posedge clk);
            pen <= 1'b1;
            k = 0;
            do begin @(posedge clk); k++; end while (prdy !== 1'b1 && k < 20);
            bound(k, 20);
            {psel, pen} <= 2'b00;
            @(posedge clk);
        end
    endtask
    always @(posedge clk) begin
        if (psel && pen && prdy === 1'b1 && !pwr) begin
            e = q.pop_front();
            check(perr, e[32], "slverr");
            check(prd, e[31:0], "rdata");
        end
    end
    task ccount(output integer c);
        begin
            c = 0;
            repeat (4) @(posedge clk);
            repeat (256) begin @(posedge clk); c += cen; end
        end
    endtask
    task psave(input o, input [2:0] cfg);
        begin
            apb(1, `PMCG_ADDR_CFG, cfg, 0);
            {req, op} <= {1'b1, o};
            @(posedge clk);
            req <= 1'b0;
            #1;
            check(wclr, o | cfg[0], "wclr");
            check(low_power_rc_oscillator, o ? |cfg[1:0] : cfg[0], "low_power_rc_oscillator");
            check(fail_safe_clock_monitor, o & cfg[1], "fail_safe_clock_monitor");
            check({osc, cen}, {o, 1'b0}, "clocks");
            if (!o) check(mclk ^ (ext ? r[7:0] : 8'h0), ext ? 8'hFF : 8'h0,
                "mclk");
        end
    endtask
    task wakeup(input w);
        integer k;
        begin
            if (w) wto <= 1'b1;
            else irq_req <= 1'b1;
            k = 0;
            do begin @(posedge clk); k++; end while (wake !== 1'b1 && k < 40);
            bound(k, 40);
            {wto, irq_req} <= 2'b00;
            check({cen, osc, aosc}, {2'b11, osv}, "wake");
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_n, psel, pen, pwr, req, op, wto, ext, irq_req} = 9'h000;
        {lat, pa, pw} = 47'h0;
        seed = 32'h0459;
        errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 7; i++) apb(0, i * 4, 0, {1'b0, (i == 2) ? 32'hFF
            : 32'h0});
        apb(0, 12'h01C, 0, {1'b1, 32'h0});
        r = $random(seed);
        osv = r[2:0];
        apb(1, `PMCG_ADDR_OSCSEL, r, 0);
        apb(1, `PMCG_ADDR_CFG, 32'h4, 0);
        apb(1, `PMCG_ADDR_OSCSEL, ~r, 0);
        apb(0, `PMCG_ADDR_OSCSEL, 0, {30'h0, osv});
        for (n = 0; n < 9; n++) begin
            apb(1, `PMCG_ADDR_CLOCK_DIVIDER_CONTROL, n < 8 ? 32'h800 | (n << 12) : 32'h7000, 0);
            ccount(i);
            check(i, n < 8 ? 256 >> n : 256, "slow");
        end
        for (n = 0; n < 2; n++) begin
            apb(1, `PMCG_ADDR_CLOCK_DIVIDER_CONTROL, 32'h3800 | (n << 15), 0);
            irq_req <= 1'b1;
            ccount(i);
            check(i, n ? 256 : 32, "roi");
            irq_req <= 1'b0;
        end
        apb(1, `PMCG_ADDR_CLOCK_DIVIDER_CONTROL, 0, 0);
        r = $random(seed);
        f = $random(seed);
        s = $random(seed);
        apb(1, `PMCG_ADDR_PWROFF, r, 0);
        apb(1, `PMCG_ADDR_FUNCEN, f, 0);
        apb(1, `PMCG_ADDR_IDLSTOP, s, 0);
        apb(0, `PMCG_ADDR_FUNCEN, 0, {25'h0, f[7:0]});
        check(mclk ^ r[7:0], 8'hFF, "mclk");
        check(mreg ^ r[7:0], 8'hFF, "mreg");
        check(mrun & ~r[7:0], f[7:0] & ~r[7:0], "mrun");
        lat <= $random(seed);
        psave(0, 3'h1);
        wakeup(1);
        psave(0, 3'h2);
        wakeup(0);
        ext <= 1'b1;
        psave(0, 3'h0);
        wakeup(0);
        ext <= 1'b0;
        psave(1, 3'h2);
        check(mrun & ~r[7:0], f[7:0] & ~s[7:0] & ~r[7:0], "idle");
        wakeup(1);
        lat <= 3'h0;
        irq_req <= 1'b1;
        psave(1, 3'h0);
        wakeup(0);
        psave(0, 3'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 check(osc, 1, "reset");
        print_verdict;
    end
endmodule
